// >>> verilog/iap_wbuf_defines.svh
// Purpose: named constants for the flash write buffer block
// Assumes: 8-bit special-register access, 12-bit flash word address
// Notes: register selects are local codes, two sectors
`ifndef IAP_WBUF_DEFINES_SVH
`define IAP_WBUF_DEFINES_SVH

// ==========================================================
// register selects: sector 0 holds address/data, sector 1 control
`define SEC_DATA 1'h0
`define SEC_CTRL 1'h1
`define REG_ADDR_LOW 4'h0
`define REG_ADDR_HIGH 4'h1
`define REG_W1_LOW 4'h2
`define REG_W1_HIGH 4'h3
`define REG_W2_LOW 4'h4
`define REG_W2_HIGH 4'h5
`define REG_W3_LOW 4'h6
`define REG_W3_HIGH 4'h7
`define REG_W4_LOW 4'h8
`define REG_W4_HIGH 4'h9
`define REG_MODE_CTRL 4'h0
`define REG_RESET_PAT 4'h1
`define REG_TIME_CLR 4'h2

// ==========================================================
// field positions
`define BIT_EW_EN 7
`define BIT_WSTART 2
`define BIT_CLR 0
`define BIT_PTS 1
`define PAGE_WORDS 32
`define PAGE_LAST 5'h1F
`define ADDR_HI_MASK 8'h0F
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define RESET_ADDR 12'h000
`define BUF_DEPTH 2

`endif

// >>> verilog/iap_wbuf_pkg.sv
// Purpose: shared types for the flash write buffer block
// Assumes: defines header compiled alongside
// Notes: holds types only
package iap_wbuf_pkg;
    // one word headed for the page buffer
    typedef struct packed {
        logic [4:0] slot;
        logic [15:0] data;
    } load_word_t;

    // register port request
    typedef struct packed {
        logic wr;
        logic sector;
        logic [3:0] sel;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// >>> verilog/iap_skid_buf.sv
// Purpose: two-entry valid/ready buffer in the load path
// Assumes: single clock, synchronous reset
// Notes: full when both entries hold data
`timescale 1ns/1ps
`include "iap_wbuf_defines.svh"
module iap_skid_buf (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input iap_wbuf_pkg::load_word_t in_word,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output iap_wbuf_pkg::load_word_t out_word,
    // flush discards pending words
    input wire logic flush
);
    import iap_wbuf_pkg::*;

    // ==========================================================
    // storage
    load_word_t mem_ff [`BUF_DEPTH];
    logic rd_ptr_ff;
    logic wr_ptr_ff;
    logic [1:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = (count_ff != 2'(`BUF_DEPTH));
    assign out_valid = (count_ff != 2'h0);
    assign out_word = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and occupancy tracking
    always_ff @(posedge clk) begin
        if (srst || flush) begin
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            count_ff <= count_ff + 2'(push) - 2'(pop);
        end
    end

    // entry write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_word;
        end
    end
endmodule

// >>> verilog/iap_flash_write_buffer.sv
// Purpose: register file and 32-word page buffer for in-application flash programming
// Assumes: register access is one byte per cycle; flash engine reports write done
// Notes: unlock and program timing live in the flash engine outside this block
//
// How it works
// [RL1] buffer accepts words only while erase/write is enabled
// [RL2] buffer-clear bit runs a clear sweep, then hardware drops the bit
// [RL3] software should clear the buffer before first use or refresh
// [RL4] buffer holds 32 words; page chosen by address bits 11..5
// [RL5] high-byte write of word one loads low and high as one word
// [RL6] low-byte write of word one only updates that register
// [RL7] each buffer load increments address and writes it back
// [RL8] in-page address saturates at 11111b
// [RL9] each completed flash write clears the whole buffer
// [RL10] on bad verify software clears and reloads the buffer
// [RL11] two address registers and four 16-bit data pairs
// [RL12] address and data registers sit in sector 0
// [RL13] three control registers sit in sector 1
// [RL14] 12-bit address; high register bits 7..4 read zero
// [RL15] each pair: low holds bits 7..0, high bits 15..8
// [RL16] enable flag set on unlock; software clear disables; writing one ignored
// [RL17] write-start flag launches programming; cleared when write completes
// [RL18] high-byte writes while disabled change neither buffer nor address
`timescale 1ns/1ps
`include "iap_wbuf_defines.svh"
module iap_flash_write_buffer (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // special-register port
    input iap_wbuf_pkg::reg_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    // flash engine handshake
    input wire logic UNLOCK_OK,
    input wire logic WRITE_DONE,
    output logic WRITE_START,
    output logic CLEAR_BUSY,
    output logic [6:0] PAGE_SEL,
    output logic [2:0] MODE_SEL,
    output logic TIME_SEL,
    output logic CHIP_RESET_REQ,
    // buffer read-out by the flash engine
    input wire logic [4:0] BUF_RD_SLOT,
    output logic [15:0] BUF_RD_DATA,
    output logic LOAD_STALL
);
    import iap_wbuf_pkg::*;

    // ==========================================================
    // state and registers
    typedef enum logic [1:0] {
        CLR_IDLE = 2'b01,
        CLR_SWEEP = 2'b10
    } clr_state_t;

    clr_state_t clr_state_ff;
    clr_state_t nxt_clr_state;
    logic [4:0] clr_idx_ff;
    logic [15:0] page_ff [`PAGE_WORDS];
    logic [11:0] addr_ff;
    logic [7:0] dlow_ff [4];
    logic [7:0] dhigh_ff [4];
    logic ew_en_ff;
    logic [2:0] mode_ff;
    logic lock_trig_ff;
    logic wstart_ff;
    logic rdenable_ff;
    logic rdgo_ff;
    logic [7:0] reset_pat_ff;
    logic pts_ff;
    logic clr_req_ff;
    logic [7:0] rdata_ff;
    logic [15:0] buf_rd_ff;
    logic stall_ff;
    logic chip_reset_ff;

    // decode helper used for both sectors
    function automatic logic hit(input reg_req_t r, input logic sec, input logic [3:0] sel);
        hit = r.wr && (r.sector == sec) && (r.sel == sel);
    endfunction

    // next address within the page, saturating at the last slot
    function automatic logic [11:0] next_addr(input logic [11:0] a);
        if (a[4:0] == `PAGE_LAST) begin
            next_addr = a; // [RL8]
        end else begin
            next_addr = a + 12'h001; // [RL7]
        end
    endfunction

    logic load_fire;
    logic q_valid;
    logic q_ready;
    logic in_ready;
    load_word_t q_word;
    load_word_t in_word;
    logic clearing;
    logic wdone;

    assign wdone = WRITE_DONE && wstart_ff;
    assign clearing = (clr_state_ff == CLR_SWEEP);
    // a load only counts when enabled and the buffer path can take it
    assign load_fire = hit(REG_REQ, `SEC_DATA, `REG_W1_HIGH) && ew_en_ff && in_ready; // [RL1] [RL18]
    assign in_word.slot = addr_ff[4:0]; // [RL4]
    assign in_word.data = {REG_REQ.wdata, dlow_ff[0]}; // [RL5] [RL15]
    // drain waits out a clear sweep so queued words land after it, not under it
    assign q_ready = !clearing;

    // ==========================================================
    // two-entry buffer between register writes and the page store
    iap_skid_buf u_skid (
        .clk(CLK_SYS),
        .srst(SRST),
        .in_valid(load_fire),
        .in_ready(in_ready),
        .in_word(in_word),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_word(q_word),
        .flush(clr_req_ff && !clearing)
    );

    // ==========================================================
    // clear sequencer
    always_comb begin
        nxt_clr_state = clr_state_ff;
        case (clr_state_ff)
            CLR_IDLE: begin
                if (clr_req_ff || wdone) begin
                    nxt_clr_state = CLR_SWEEP; // [RL2] [RL9]
                end
            end
            CLR_SWEEP: begin
                if (clr_idx_ff == `PAGE_LAST) begin
                    nxt_clr_state = CLR_IDLE;
                end
            end
            default: nxt_clr_state = CLR_IDLE;
        endcase
    end

    // sequencer state and sweep index
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            clr_state_ff <= CLR_IDLE;
            clr_idx_ff <= 5'h00;
        end else begin
            clr_state_ff <= nxt_clr_state;
            clr_idx_ff <= clearing ? clr_idx_ff + 5'h01 : 5'h00;
        end
    end

    // page store: one word per cycle swept, or one drained load
    always_ff @(posedge CLK_SYS) begin
        if (clearing) begin
            page_ff[clr_idx_ff] <= `RESET_WORD; // [RL2] [RL9]
        end else if (q_valid) begin
            page_ff[q_word.slot] <= q_word.data; // [RL4] [RL5]
        end
    end

    // ==========================================================
    // address registers in sector 0
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            addr_ff <= `RESET_ADDR;
        end else if (load_fire) begin
            addr_ff <= next_addr(addr_ff); // [RL7] [RL8]
        end else if (hit(REG_REQ, `SEC_DATA, `REG_ADDR_LOW)) begin
            addr_ff[7:0] <= REG_REQ.wdata; // [RL12] [RL14]
        end else if (hit(REG_REQ, `SEC_DATA, `REG_ADDR_HIGH)) begin
            addr_ff[11:8] <= REG_REQ.wdata[3:0]; // [RL14]
        end
    end

    // data pairs; a low write stores only there
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            for (int i = 0; i < 4; i++) begin
                dlow_ff[i] <= `RESET_BYTE;
                dhigh_ff[i] <= `RESET_BYTE;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (hit(REG_REQ, `SEC_DATA, 4'(`REG_W1_LOW + 2 * i))) begin
                    dlow_ff[i] <= REG_REQ.wdata; // [RL6] [RL11] [RL15]
                end
                if (hit(REG_REQ, `SEC_DATA, 4'(`REG_W1_HIGH + 2 * i))) begin
                    dhigh_ff[i] <= REG_REQ.wdata; // [RL11] [RL15]
                end
            end
        end
    end

    // ==========================================================
    // control registers in sector 1
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ew_en_ff <= 1'b0;
        end else if (UNLOCK_OK) begin
            ew_en_ff <= 1'b1; // [RL16] set wins over a same-cycle clear
        end else if (hit(REG_REQ, `SEC_CTRL, `REG_MODE_CTRL) && !REG_REQ.wdata[`BIT_EW_EN]) begin
            ew_en_ff <= 1'b0; // [RL16] [RL13]
        end
    end

    // write-start flag, hardware clear on completion
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            wstart_ff <= 1'b0;
        end else if (hit(REG_REQ, `SEC_CTRL, `REG_MODE_CTRL)) begin
            wstart_ff <= REG_REQ.wdata[`BIT_WSTART] && ew_en_ff; // [RL17]
        end else if (wdone) begin
            wstart_ff <= 1'b0; // [RL17]
        end
    end

    // remaining mode bits are plain storage for the engine
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            mode_ff <= 3'h0;
            lock_trig_ff <= 1'b0;
            rdenable_ff <= 1'b0;
            rdgo_ff <= 1'b0;
            reset_pat_ff <= `RESET_BYTE;
            pts_ff <= 1'b0;
        end else begin
            if (hit(REG_REQ, `SEC_CTRL, `REG_MODE_CTRL)) begin
                mode_ff <= REG_REQ.wdata[6:4];
                lock_trig_ff <= REG_REQ.wdata[3];
                rdenable_ff <= REG_REQ.wdata[1];
                rdgo_ff <= REG_REQ.wdata[0];
            end
            if (hit(REG_REQ, `SEC_CTRL, `REG_RESET_PAT)) begin
                reset_pat_ff <= REG_REQ.wdata;
            end
            if (hit(REG_REQ, `SEC_CTRL, `REG_TIME_CLR)) begin
                pts_ff <= REG_REQ.wdata[`BIT_PTS];
            end
        end
    end

    // clear trigger: set by software, dropped when the sweep ends
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            clr_req_ff <= 1'b0;
        end else if (hit(REG_REQ, `SEC_CTRL, `REG_TIME_CLR) && REG_REQ.wdata[`BIT_CLR]) begin
            clr_req_ff <= 1'b1; // [RL2]
        end else if (clearing && nxt_clr_state == CLR_IDLE) begin
            clr_req_ff <= 1'b0; // [RL2]
        end
    end

    // ==========================================================
    // read mux, registered one cycle after the select
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rdata_ff <= `RESET_BYTE;
        end else if (REG_REQ.sector == `SEC_CTRL) begin
            case (REG_REQ.sel)
                `REG_MODE_CTRL: rdata_ff <= {ew_en_ff, mode_ff, lock_trig_ff, wstart_ff, rdenable_ff, rdgo_ff};
                `REG_RESET_PAT: rdata_ff <= reset_pat_ff;
                `REG_TIME_CLR: rdata_ff <= {6'h00, pts_ff, clr_req_ff};
                default: rdata_ff <= `RESET_BYTE;
            endcase
        end else begin
            case (REG_REQ.sel)
                `REG_ADDR_LOW: rdata_ff <= addr_ff[7:0];
                `REG_ADDR_HIGH: rdata_ff <= {4'h0, addr_ff[11:8]} & `ADDR_HI_MASK; // [RL14]
                `REG_W1_LOW: rdata_ff <= dlow_ff[0];
                `REG_W1_HIGH: rdata_ff <= dhigh_ff[0];
                `REG_W2_LOW: rdata_ff <= dlow_ff[1];
                `REG_W2_HIGH: rdata_ff <= dhigh_ff[1];
                `REG_W3_LOW: rdata_ff <= dlow_ff[2];
                `REG_W3_HIGH: rdata_ff <= dhigh_ff[2];
                `REG_W4_LOW: rdata_ff <= dlow_ff[3];
                `REG_W4_HIGH: rdata_ff <= dhigh_ff[3];
                default: rdata_ff <= `RESET_BYTE;
            endcase
        end
    end

    // engine-facing outputs, all from flip-flops
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            buf_rd_ff <= `RESET_WORD;
            stall_ff <= 1'b0;
            chip_reset_ff <= 1'b0;
        end else begin
            buf_rd_ff <= page_ff[BUF_RD_SLOT];
            stall_ff <= !in_ready;
            chip_reset_ff <= 1'b0; // pattern decode belongs to the reset block
        end
    end

    assign REG_RDATA = rdata_ff;
    assign WRITE_START = wstart_ff;
    assign CLEAR_BUSY = clr_req_ff;
    assign PAGE_SEL = addr_ff[11:5]; // [RL4]
    assign MODE_SEL = mode_ff;
    assign TIME_SEL = pts_ff;
    assign CHIP_RESET_REQ = chip_reset_ff;
    assign BUF_RD_DATA = buf_rd_ff;
    assign LOAD_STALL = stall_ff;
endmodule

// >>> verification/iap_wbuf_assertions.sv
// Purpose: port-level checks for the flash write buffer
// Assumes: selects and bit positions as in the defines header
// Notes: enable flag is shadowed from UNLOCK_OK and control writes
`timescale 1ns/1ps
module iap_wbuf_assertions (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // register port
    input iap_wbuf_pkg::reg_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    // engine side
    input wire logic UNLOCK_OK,
    input wire logic WRITE_DONE,
    input wire logic WRITE_START,
    input wire logic CLEAR_BUSY,
    input wire logic [6:0] PAGE_SEL,
    input wire logic [2:0] MODE_SEL,
    input wire logic TIME_SEL
);
    import iap_wbuf_pkg::*;
    // ==========================================================
    // helpers
    logic en_ff;
    logic s0, s1, addr_wr;
    assign s0 = REG_REQ.sector == 1'h0;
    assign s1 = REG_REQ.sector == 1'h1;
    assign addr_wr = REG_REQ.wr && s0 && REG_REQ.sel <= 4'h1;
    // shadow of the enable flag; a set wins over a software clear
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            en_ff <= 1'h0;
        end else if (UNLOCK_OK) begin
            en_ff <= 1'h1;
        end else if (REG_REQ.wr && s1 && REG_REQ.sel == 4'h0 && !REG_REQ.wdata[7]) begin
            en_ff <= 1'h0;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    // ==========================================================
    // assertions
    AST_CLR_SET: assert property (REG_REQ.wr && s1 && REG_REQ.sel == 4'h2 && REG_REQ.wdata[0] |=> CLEAR_BUSY)
        else $error("clear bit not set by write");
    AST_CLR_ENDS: assert property ($rose(CLEAR_BUSY) |-> ##[1:40] !CLEAR_BUSY)
        else $error("clear bit never dropped");
    AST_WSTART_DONE: assert property (WRITE_START && WRITE_DONE |=> !WRITE_START)
        else $error("write start not cleared on done");
    AST_WSTART_LOCK: assert property (!en_ff && !WRITE_START |=> !WRITE_START)
        else $error("write start set while disabled");
    AST_ADDRH_RD: assert property (s0 && REG_REQ.sel == 4'h1 |=> REG_RDATA[7:4] == 4'h0)
        else $error("address high upper bits not zero");
    AST_CTRL2_RD: assert property (s1 && REG_REQ.sel == 4'h2 |=> REG_RDATA[7:2] == 6'h00)
        else $error("unused control bits not zero");
    AST_PAGE_HI: assert property (addr_wr && REG_REQ.sel == 4'h1 |=> PAGE_SEL[6:3] == $past(REG_REQ.wdata[3:0]))
        else $error("page upper bits wrong");
    AST_PAGE_LO: assert property (addr_wr && REG_REQ.sel == 4'h0 |=> PAGE_SEL[2:0] == $past(REG_REQ.wdata[7:5]))
        else $error("page lower bits wrong");
    AST_PAGE_HOLD: assert property (!addr_wr |=> $stable(PAGE_SEL))
        else $error("page moved without address write");
    AST_TIME_SEL: assert property (REG_REQ.wr && s1 && REG_REQ.sel == 4'h2 |=> TIME_SEL == $past(REG_REQ.wdata[1]))
        else $error("time select not stored");
    AST_MODE_SEL: assert property (REG_REQ.wr && s1 && REG_REQ.sel == 4'h0 |=> MODE_SEL == $past(REG_REQ.wdata[6:4]))
        else $error("mode bits not stored");
endmodule

bind iap_flash_write_buffer iap_wbuf_assertions chk_i (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .UNLOCK_OK(UNLOCK_OK),
    .WRITE_DONE(WRITE_DONE), .WRITE_START(WRITE_START), .CLEAR_BUSY(CLEAR_BUSY), .PAGE_SEL(PAGE_SEL),
    .MODE_SEL(MODE_SEL), .TIME_SEL(TIME_SEL)
);

// >>> verification/testbench.sv
// Purpose: self-checking bench for the flash write buffer
// Assumes: 50 MHz clock, sync reset held 4 cycles
// Notes: page store is not reset, so a clear runs first
`timescale 1ns/1ps
module testbench;
    import iap_wbuf_pkg::*;
    // ==========================================================
    // signals
    logic CLK_SYS, SRST, UNLOCK_OK, WRITE_DONE;
    logic WRITE_START, CLEAR_BUSY, TIME_SEL, CHIP_RESET_REQ, LOAD_STALL;
    logic [7:0] REG_RDATA;
    logic [6:0] PAGE_SEL;
    logic [2:0] MODE_SEL;
    logic [4:0] BUF_RD_SLOT;
    logic [15:0] BUF_RD_DATA;
    iap_wbuf_pkg::reg_req_t req;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] b;
    logic [15:0] w;
    iap_flash_write_buffer uut (
        .CLK_SYS(CLK_SYS), .SRST(SRST), .REG_REQ(req), .REG_RDATA(REG_RDATA), .UNLOCK_OK(UNLOCK_OK),
        .WRITE_DONE(WRITE_DONE), .WRITE_START(WRITE_START), .CLEAR_BUSY(CLEAR_BUSY), .PAGE_SEL(PAGE_SEL),
        .MODE_SEL(MODE_SEL), .TIME_SEL(TIME_SEL), .CHIP_RESET_REQ(CHIP_RESET_REQ),
        .BUF_RD_SLOT(BUF_RD_SLOT), .BUF_RD_DATA(BUF_RD_DATA), .LOAD_STALL(LOAD_STALL)
    );
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic sec, input logic [3:0] sel, input logic [7:0] d);
        @(posedge CLK_SYS);
        req <= '{1'b1, sec, sel, d};
        @(posedge CLK_SYS);
        req.wr <= 1'b0;
    endtask
    // read data is registered, so sample one edge after the select
    task automatic rd(input logic sec, input logic [3:0] sel);
        @(posedge CLK_SYS);
        req <= '{1'b0, sec, sel, 8'h00};
        @(posedge CLK_SYS);
        #1 b = REG_RDATA;
    endtask
    task automatic brd(input logic [4:0] slot);
        @(posedge CLK_SYS);
        BUF_RD_SLOT <= slot;
        @(posedge CLK_SYS);
        #1 w = BUF_RD_DATA;
    endtask
    task automatic load(input logic [7:0] lo, input logic [7:0] hi);
        wr(1'b0, 4'h2, lo);
        wr(1'b0, 4'h3, hi);
    endtask
    task automatic wait_clr();
        int n = 0;
        #1;
        while (CLEAR_BUSY !== 1'b0 && n < 80) begin
            @(posedge CLK_SYS);
            #1 n++;
        end
        chk({15'h0000, CLEAR_BUSY}, 16'h0000);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        for (int i = 0; i < 10; i++) begin
            rd(1'b0, 4'(i));
            chk({8'h00, b}, 16'h0000);
        end
        for (int i = 0; i < 3; i++) begin
            rd(1'b1, 4'(i));
            chk({8'h00, b}, 16'h0000);
        end
        // reset pattern is plain storage; no chip reset is raised here
        wr(1'b1, 4'h1, 8'h3C);
        rd(1'b1, 4'h1);
        chk({8'h00, b}, 16'h003C);
        chk({15'h0000, CHIP_RESET_REQ}, 16'h0000);
    endtask
    // clear before first use leaves every slot zero
    task automatic t_clear();
        wr(1'b1, 4'h2, 8'h01);
        wait_clr();
        rd(1'b1, 4'h2);
        chk({8'h00, b}, 16'h0000);
        for (int i = 0; i < 32; i++) begin
            brd(5'(i));
            chk(w, 16'h0000);
        end
    endtask
    task automatic t_locked();
        wr(1'b1, 4'h0, 8'hB0);
        #1 chk({13'h0000, MODE_SEL}, 16'h0003);
        rd(1'b1, 4'h0);
        chk({8'h00, b}, 16'h0030);
        wr(1'b1, 4'h0, 8'h04);
        #1 chk({15'h0000, WRITE_START}, 16'h0000);
        load(8'h34, 8'h12);
        rd(1'b0, 4'h0);
        chk({8'h00, b}, 16'h0000);
        brd(5'h00);
        chk(w, 16'h0000);
        rd(1'b0, 4'h3);
        chk({8'h00, b}, 16'h0012);
    endtask
    // loads run past the page end; the last slot takes the overflow
    task automatic t_load();
        @(posedge CLK_SYS);
        UNLOCK_OK <= 1'b1;
        @(posedge CLK_SYS);
        UNLOCK_OK <= 1'b0;
        rd(1'b1, 4'h0);
        chk({8'h00, b}, 16'h0080);
        wr(1'b0, 4'h1, 8'hFA);
        wr(1'b0, 4'h0, 8'h5C);
        #1 chk({9'h000, PAGE_SEL}, 16'h0052);
        for (int i = 0; i < 5; i++) load(8'(i + 1), 8'(8'hC0 + i));
        rd(1'b0, 4'h0);
        chk({8'h00, b}, 16'h005F);
        rd(1'b0, 4'h1);
        chk({8'h00, b}, 16'h000A);
        for (int i = 0; i < 4; i++) begin
            brd(5'(28 + i));
            chk(w, (i == 3) ? 16'hC405 : {8'(8'hC0 + i), 8'(i + 1)});
        end
        wr(1'b0, 4'h2, 8'hEE);
        rd(1'b0, 4'h0);
        chk({8'h00, b}, 16'h005F);
        brd(5'h1F);
        chk(w, 16'hC405);
        for (int i = 4; i < 10; i++) wr(1'b0, 4'(i), 8'(i * 17));
        for (int i = 4; i < 10; i++) begin
            rd(1'b0, 4'(i));
            chk({8'h00, b}, 16'(i * 17));
        end
    endtask
    task automatic t_done();
        wr(1'b1, 4'h0, 8'h84);
        #1 chk({15'h0000, WRITE_START}, 16'h0001);
        @(posedge CLK_SYS);
        WRITE_DONE <= 1'b1;
        @(posedge CLK_SYS);
        WRITE_DONE <= 1'b0;
        #1 chk({15'h0000, WRITE_START}, 16'h0000);
        repeat (40) @(posedge CLK_SYS);
        brd(5'h1C);
        chk(w, 16'h0000);
        brd(5'h1F);
        chk(w, 16'h0000);
    endtask
    // burst of loads during a sweep fills the queue; the third is refused
    task automatic t_stall();
        logic seen = 1'b0;
        wr(1'b0, 4'h0, 8'h40);
        wr(1'b0, 4'h2, 8'h00);
        wr(1'b1, 4'h2, 8'h03);
        @(posedge CLK_SYS);
        req <= '{1'b1, 1'b0, 4'h3, 8'hA1};
        @(posedge CLK_SYS);
        req.wdata <= 8'hA2;
        @(posedge CLK_SYS);
        req.wdata <= 8'hA3;
        @(posedge CLK_SYS);
        req.wr <= 1'b0;
        repeat (3) begin
            @(posedge CLK_SYS);
            #1 seen |= LOAD_STALL;
        end
        chk({15'h0000, seen}, 16'h0001);
        chk({15'h0000, TIME_SEL}, 16'h0001);
        wait_clr();
        repeat (4) @(posedge CLK_SYS);
        rd(1'b0, 4'h0);
        chk({8'h00, b}, 16'h0042);
        for (int i = 0; i < 3; i++) begin
            brd(5'(i));
            chk(w, (i == 2) ? 16'h0000 : {8'(8'hA1 + i), 8'h00});
        end
        // bad verify: clear by hand, then reload the page
        wr(1'b1, 4'h2, 8'h01);
        wait_clr();
        wr(1'b0, 4'h0, 8'h40);
        load(8'h5A, 8'hA5);
        repeat (2) @(posedge CLK_SYS);
        brd(5'h00);
        chk(w, 16'hA55A);
        brd(5'h01);
        chk(w, 16'h0000);
        wr(1'b1, 4'h0, 8'h00);
        rd(1'b1, 4'h0);
        chk({8'h00, b}, 16'h0000);
    endtask
    // ==========================================================
    // verdict and hang guard
    task test_done;
        if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end
    // free-running 20 ns clock
    initial begin
        CLK_SYS = 1'b0;
        forever #10 CLK_SYS = ~CLK_SYS;
    end
    // main sequence
    initial begin
        SRST = 1'b1;
        UNLOCK_OK = 1'b0;
        WRITE_DONE = 1'b0;
        BUF_RD_SLOT = 5'h00;
        req = '0;
        repeat (4) @(posedge CLK_SYS);
        SRST <= 1'b0;
        t_reset();
        t_clear();
        t_locked();
        t_load();
        t_done();
        t_stall();
        test_done();
    end
endmodule
